// >>> isoch_dma_context_control.sv
/*
 * isochronous dma context control: transmit first-descriptor
 * pointers, receive context control with set/clear views, cycle
 * match start and the receive packet formatter.
 * assumes a descriptor fetch engine reporting fetch addresses, a
 * link layer delivering received quadlets and cycle-start events,
 * all synchronous to clk.
 */
`timescale 1ns/1ps
module isoch_dma_context_control (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [11:0] addr,
    input wire logic [31:0] wr_data,
    output logic [31:0] rd_data_ff,
    // fetch engine and link
    input wire isoch_dma_pkg::tx_fetch_s tx_fetch,
    input wire isoch_dma_pkg::cycle_start_s cycle_start,
    input wire isoch_dma_pkg::rx_beat_s rx_beat,
    // receive side results
    output isoch_dma_pkg::store_word_s store_ff,
    output logic [3:0] rx_active_ff
);

    // ***********************************************************
    // state
    // ***********************************************************
    logic [31:0] tx_ptr_ff [isoch_dma_pkg::TX_CTX_NUM];
    logic [3:0] fill_ff;
    logic [3:0] hdr_ff;
    logic [3:0] cme_ff;
    logic [3:0] run_ff;
    logic [12:0] match_ff [isoch_dma_pkg::RX_CTX_NUM];
    isoch_dma_pkg::rx_state_e state_ff [isoch_dma_pkg::RX_CTX_NUM];
    isoch_dma_pkg::rx_state_e nxt_state [isoch_dma_pkg::RX_CTX_NUM];
    logic [15:0] stamp_ff;
    logic pkt_first_ff;

    logic tx_hit;
    logic [2:0] tx_idx;
    logic [3:0] set_wr;
    logic [3:0] clr_wr;
    logic [3:0] set_rd;
    logic [3:0] clr_rd;
    logic [3:0] match_wr;
    logic [3:0] match_rd;
    logic [31:0] nxt_rd_data;
    logic beat_act;
    logic beat_hdr;
    logic beat_fill;

    // ***********************************************************
    // address decode
    // ***********************************************************
    always_comb begin
        tx_hit = 1'b0;
        tx_idx = 3'h0;
        for (int i = 0; i < isoch_dma_pkg::TX_CTX_NUM; i++) begin
            if (addr == isoch_dma_pkg::TX_PTR_BASE
                    + 12'(i) * isoch_dma_pkg::TX_PTR_STRIDE) begin
                tx_hit = 1'b1;
                tx_idx = 3'(i);
            end
        end
        for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
            set_rd[i] = addr == isoch_dma_pkg::RX_SET_BASE
                + 12'(i) * isoch_dma_pkg::RX_STRIDE;
            clr_rd[i] = addr == isoch_dma_pkg::RX_CLR_BASE
                + 12'(i) * isoch_dma_pkg::RX_STRIDE;
            match_rd[i] = addr == isoch_dma_pkg::RX_MATCH_BASE
                + 12'(i) * isoch_dma_pkg::RX_STRIDE;
            set_wr[i] = wr_en && set_rd[i];
            clr_wr[i] = wr_en && clr_rd[i];
            match_wr[i] = wr_en && match_rd[i];
        end
    end

    // ***********************************************************
    // read mux
    // ***********************************************************
    always_comb begin
        nxt_rd_data = isoch_dma_pkg::ZERO_WORD;
        if (tx_hit) begin
            nxt_rd_data = tx_ptr_ff[tx_idx];
        end
        for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
            if (set_rd[i] || clr_rd[i]) begin
                nxt_rd_data[isoch_dma_pkg::FILL_BIT] = fill_ff[i];
                nxt_rd_data[isoch_dma_pkg::HDR_BIT] = hdr_ff[i];
                nxt_rd_data[isoch_dma_pkg::CME_BIT] = cme_ff[i];
                nxt_rd_data[isoch_dma_pkg::RUN_BIT] = run_ff[i];
                nxt_rd_data[isoch_dma_pkg::ACTIVE_BIT] = rx_active_ff[i];
            end
            if (match_rd[i]) begin
                nxt_rd_data[isoch_dma_pkg::MATCH_MSB:isoch_dma_pkg::MATCH_LSB]
                    = match_ff[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data_ff <= isoch_dma_pkg::ZERO_WORD;
        end else if (ce) begin
            rd_data_ff <= rd_en ? nxt_rd_data : isoch_dma_pkg::ZERO_WORD;
        end
    end

    // ***********************************************************
    // transmit first-descriptor pointers
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < isoch_dma_pkg::TX_CTX_NUM; i++) begin
                tx_ptr_ff[i] <= isoch_dma_pkg::ZERO_WORD;
            end
        end else if (ce && tx_fetch.valid) begin
            tx_ptr_ff[tx_fetch.ctx] <= tx_fetch.addr;
        end
    end

    // ***********************************************************
    // receive options, run and match
    // ***********************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            fill_ff <= 4'h0;
            hdr_ff <= 4'h0;
            cme_ff <= 4'h0;
            run_ff <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
                if (set_wr[i]) begin
                    fill_ff[i] <= fill_ff[i]
                        | wr_data[isoch_dma_pkg::FILL_BIT];
                    hdr_ff[i] <= hdr_ff[i] | wr_data[isoch_dma_pkg::HDR_BIT];
                    run_ff[i] <= run_ff[i]
                        | wr_data[isoch_dma_pkg::RUN_BIT];
                end else if (clr_wr[i]) begin
                    fill_ff[i] <= fill_ff[i]
                        & ~wr_data[isoch_dma_pkg::FILL_BIT];
                    hdr_ff[i] <= hdr_ff[i]
                        & ~wr_data[isoch_dma_pkg::HDR_BIT];
                    run_ff[i] <= run_ff[i]
                        & ~wr_data[isoch_dma_pkg::RUN_BIT];
                end
                if (set_wr[i] && wr_data[isoch_dma_pkg::CME_BIT]) begin
                    cme_ff[i] <= 1'b1;
                end else if (clr_wr[i]
                        && wr_data[isoch_dma_pkg::CME_BIT]) begin
                    cme_ff[i] <= 1'b0;
                end else if (rx_active_ff[i]) begin
                    cme_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
                match_ff[i] <= isoch_dma_pkg::MATCH_RESET;
            end
        end else if (ce) begin
            for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
                if (match_wr[i]) begin
                    match_ff[i] <= wr_data[isoch_dma_pkg::MATCH_MSB:
                                           isoch_dma_pkg::MATCH_LSB];
                end
            end
        end
    end

    // ***********************************************************
    // receive context start sequencing
    // ***********************************************************
    always_comb begin
        for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
            nxt_state[i] = state_ff[i];
            case (state_ff[i])
                isoch_dma_pkg::RX_IDLE: begin
                    if (run_ff[i] && cme_ff[i]) begin
                        nxt_state[i] = isoch_dma_pkg::RX_WAIT;
                    end else if (run_ff[i]) begin
                        nxt_state[i] = isoch_dma_pkg::RX_RUN;
                    end
                end
                isoch_dma_pkg::RX_WAIT: begin
                    if (!run_ff[i]) begin
                        nxt_state[i] = isoch_dma_pkg::RX_IDLE;
                    end else if (cycle_start.valid
                            && cycle_start.count == match_ff[i]) begin
                        nxt_state[i] = isoch_dma_pkg::RX_RUN;
                    end
                end
                isoch_dma_pkg::RX_RUN: begin
                    if (!run_ff[i]) begin
                        nxt_state[i] = isoch_dma_pkg::RX_IDLE;
                    end
                end
                default: begin
                    nxt_state[i] = isoch_dma_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
                state_ff[i] <= isoch_dma_pkg::RX_IDLE;
            end
            rx_active_ff <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < isoch_dma_pkg::RX_CTX_NUM; i++) begin
                state_ff[i] <= nxt_state[i];
                rx_active_ff[i] <= nxt_state[i]
                    == isoch_dma_pkg::RX_RUN;
            end
        end
    end

    // ***********************************************************
    // receive packet formatter
    // ***********************************************************
    assign beat_act = rx_beat.valid && rx_active_ff[rx_beat.ctx];
    assign beat_hdr = hdr_ff[rx_beat.ctx];
    assign beat_fill = fill_ff[rx_beat.ctx];

    always_ff @(posedge clk) begin
        if (reset) begin
            stamp_ff <= 16'h0000;
        end else if (ce && cycle_start.valid) begin
            stamp_ff <= cycle_start.stamp;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            store_ff <= '0;
            pkt_first_ff <= 1'b1;
        end else if (ce) begin
            store_ff.valid <= 1'b0;
            store_ff.ctx <= rx_beat.ctx;
            store_ff.buf_start <= !beat_fill && pkt_first_ff;
            if (beat_act && rx_beat.is_end) begin
                pkt_first_ff <= 1'b1;
                store_ff.valid <= beat_hdr;
                store_ff.data <= {rx_beat.status, stamp_ff};
            end else if (beat_act && rx_beat.is_header) begin
                store_ff.buf_start <= !beat_fill;
                store_ff.valid <= beat_hdr;
                store_ff.data <= rx_beat.data;
                pkt_first_ff <= !beat_hdr;
            end else if (beat_act) begin
                store_ff.valid <= 1'b1;
                store_ff.data <= rx_beat.data;
                pkt_first_ff <= 1'b0;
            end
        end
    end

    // ***********************************************************
    // assertions
    // ***********************************************************
    sequence s_tx0_read;
        ce && rd_en && addr == isoch_dma_pkg::TX_PTR_BASE;
    endsequence

    property p_tx_read;
        @(posedge clk) disable iff (reset)
        s_tx0_read |=> rd_data_ff == $past(tx_ptr_ff[0]);
    endproperty
    a_tx_read: assert property (p_tx_read)
        else $error("tx pointer read data wrong");

    property p_tx_load;
        @(posedge clk) disable iff (reset)
        ce && tx_fetch.valid && tx_fetch.ctx == 3'h5
            |=> tx_ptr_ff[5] == $past(tx_fetch.addr);
    endproperty
    a_tx_load: assert property (p_tx_load)
        else $error("tx pointer not loaded from fetch");

    sequence s_start_plain;
        ce && state_ff[0] == isoch_dma_pkg::RX_IDLE && run_ff[0]
            && !cme_ff[0];
    endsequence

    property p_start_plain;
        @(posedge clk) disable iff (reset)
        s_start_plain ##1 ce && run_ff[0] |=> rx_active_ff[0];
    endproperty
    a_start_plain: assert property (p_start_plain)
        else $error("context did not start at once");

    property p_wait_match;
        @(posedge clk) disable iff (reset)
        ce && state_ff[0] == isoch_dma_pkg::RX_WAIT
            && !(cycle_start.valid && cycle_start.count == match_ff[0])
            |=> !rx_active_ff[0];
    endproperty
    a_wait_match: assert property (p_wait_match)
        else $error("context ran before cycle match");

    property p_cme_clear;
        @(posedge clk) disable iff (reset)
        ce && rx_active_ff[2] && !set_wr[2] |=> !cme_ff[2];
    endproperty
    a_cme_clear: assert property (p_cme_clear)
        else $error("cycle match enable not cleared");

    property p_run_sw_only;
        @(posedge clk) disable iff (reset)
        !(ce && (set_wr[0] || clr_wr[0])) |=> $stable(run_ff[0]);
    endproperty
    a_run_sw_only: assert property (p_run_sw_only)
        else $error("run changed without software");

    property p_hdr_strip;
        @(posedge clk) disable iff (reset)
        ce && rx_beat.valid && rx_beat.is_header && !rx_beat.is_end
            && !beat_hdr |=> !store_ff.valid;
    endproperty
    a_hdr_strip: assert property (p_hdr_strip)
        else $error("header stored while stripping");

    property p_trailer;
        @(posedge clk) disable iff (reset)
        ce && beat_act && rx_beat.is_end && beat_hdr
            |=> store_ff.valid
            && store_ff.data == {$past(rx_beat.status), $past(stamp_ff)};
    endproperty
    a_trailer: assert property (p_trailer)
        else $error("trailer word wrong");

    property p_active_run;
        @(posedge clk) disable iff (reset)
        ce && !run_ff[0] |=> !rx_active_ff[0];
    endproperty
    a_active_run: assert property (p_active_run)
        else $error("active without processing");

endmodule : isoch_dma_context_control

// >>> isoch_dma_context_control_test.sv
/*
 * self-checking bench: register reads and writes, descriptor
 * fetches, context starts and the receive formatter.
 * assumes the link model and the package beside it.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("BAD %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module isoch_dma_context_control_test;
    logic clk;
    logic reset;
    logic ce;
    logic rd_en;
    logic wr_en;
    logic [11:0] addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    isoch_dma_pkg::tx_fetch_s tx_fetch;
    isoch_dma_pkg::cycle_start_s cycle_start;
    isoch_dma_pkg::rx_beat_s rx_beat;
    isoch_dma_pkg::store_word_s store;
    logic [3:0] rx_active;
    isoch_dma_pkg::store_word_s store_q[$];
    int n_fail;
    int checks_done;

    isoch_dma_context_control u_dut (
        .clk(clk), .reset(reset), .ce(ce), .rd_en(rd_en),
        .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
        .rd_data_ff(rd_data), .tx_fetch(tx_fetch),
        .cycle_start(cycle_start), .rx_beat(rx_beat),
        .store_ff(store), .rx_active_ff(rx_active)
    );
    isoch_link_model u_link (
        .clk(clk), .tx_fetch(tx_fetch), .cycle_start(cycle_start),
        .rx_beat(rx_beat)
    );

    // ********************************
    // helpers
    // ********************************
    function automatic logic [11:0] rxa(input logic [11:0] b, int n);
        return b + 12'(n) * isoch_dma_pkg::RX_STRIDE;
    endfunction : rxa

    function automatic isoch_dma_pkg::store_word_s sw(
        input logic [1:0] c, input logic bs, input logic [31:0] d);
        return {1'b1, c, bs, d};
    endfunction : sw

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rd_data, e)
    endtask : rd_chk

    task automatic wait_act(input int idx, input logic e);
        int i;
        for (i = 0; i < 40; i++) begin
            if (rx_active[idx] === e) begin
                break;
            end
            @(posedge clk);
        end
        if (i == 40) begin
            n_fail++;
            $display("BAD %0t active wait ran out", $time);
            stop_test();
        end
        `CHK(rx_active[idx], e)
    endtask : wait_act

    task automatic pop_chk(input isoch_dma_pkg::store_word_s e);
        isoch_dma_pkg::store_word_s g;
        g = '0;
        if (store_q.size() > 0) begin
            g = store_q.pop_front();
        end
        `CHK(g, e)
    endtask : pop_chk

    always @(posedge clk) begin
        if (store.valid === 1'b1) begin
            store_q.push_back(store);
        end
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 12'h0000;
        wr_data = 32'h0000_0000;
        n_fail = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd_chk(12'h020c, 32'h0000_0000);
        rd_chk(rxa(isoch_dma_pkg::RX_SET_BASE, 0), 32'h0000_0000);
        rd_chk(12'h0ff0, 32'h0000_0000);
        // first descriptor pointers, read back at their offsets
        for (int n = 0; n < 8; n++) begin
            u_link.fetch(3'(n), 32'h8000_0000 + 32'(n * 272));
        end
        for (int n = 0; n < 8; n++) begin
            rd_chk(12'h020c + 12'(16 * n),
                   32'h8000_0000 + 32'(n * 272));
        end
        wr(12'h023c, 32'hdead_beef);
        rd_chk(12'h023c, 32'h8000_0330);
        // set and clear views of every receive context
        for (int n = 0; n < 4; n++) begin
            wr(rxa(isoch_dma_pkg::RX_SET_BASE, n), 32'hc000_0400);
            rd_chk(rxa(isoch_dma_pkg::RX_CLR_BASE, n),
                   32'hc000_0000);
            wr(rxa(isoch_dma_pkg::RX_CLR_BASE, n), 32'h8000_0000);
            rd_chk(rxa(isoch_dma_pkg::RX_SET_BASE, n),
                   32'h4000_0000);
        end
        wr(rxa(isoch_dma_pkg::RX_MATCH_BASE, 3), 32'hffff_ffff);
        rd_chk(rxa(isoch_dma_pkg::RX_MATCH_BASE, 3), 32'h01ff_f000);
        // context 0: header kept, one buffer per packet
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 0), 32'h0000_8000);
        wait_act(0, 1'b1);
        rd_chk(rxa(isoch_dma_pkg::RX_SET_BASE, 0), 32'h4000_8400);
        u_link.cyc(13'h0005, 16'ha5c3);
        u_link.beat(2'd0, 1'b1, 1'b0, 32'h1234_5678, 16'h0000);
        u_link.beat(2'd0, 1'b0, 1'b0, 32'h0bad_f00d, 16'h0000);
        u_link.beat(2'd0, 1'b0, 1'b1, 32'h0000_0000, 16'h0011);
        repeat (3) @(posedge clk);
        pop_chk(sw(2'd0, 1'b1, 32'h1234_5678));
        pop_chk(sw(2'd0, 1'b0, 32'h0bad_f00d));
        pop_chk(sw(2'd0, 1'b0, 32'h0011_a5c3));
        // context 1: header stripped, packed buffers
        wr(rxa(isoch_dma_pkg::RX_CLR_BASE, 1), 32'h4000_0000);
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 1), 32'h8000_0000);
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 1), 32'h0000_8000);
        wait_act(1, 1'b1);
        u_link.beat(2'd1, 1'b1, 1'b0, 32'h5555_0001, 16'h0000);
        u_link.beat(2'd1, 1'b0, 1'b0, 32'h5555_0002, 16'h0000);
        u_link.beat(2'd3, 1'b0, 1'b0, 32'h7777_0000, 16'h0000);
        u_link.beat(2'd1, 1'b0, 1'b0, 32'h5555_0003, 16'h0000);
        u_link.beat(2'd1, 1'b0, 1'b1, 32'h0000_0000, 16'h0022);
        repeat (3) @(posedge clk);
        pop_chk(sw(2'd1, 1'b0, 32'h5555_0002));
        pop_chk(sw(2'd1, 1'b0, 32'h5555_0003));
        `CHK(store_q.size(), 0)
        // context 2: start held for a matching cycle
        wr(rxa(isoch_dma_pkg::RX_MATCH_BASE, 2), 32'h0012_3000);
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 2), 32'h2000_0000);
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 2), 32'h0000_8000);
        u_link.cyc(13'h0124, 16'h0001);
        repeat (4) @(posedge clk);
        `CHK(rx_active[2], 1'b0)
        u_link.cyc(13'h0123, 16'h0002);
        wait_act(2, 1'b1);
        repeat (3) @(posedge clk);
        rd_chk(rxa(isoch_dma_pkg::RX_SET_BASE, 2), 32'h4000_8400);
        // stopping context 0 ends its processing
        wr(rxa(isoch_dma_pkg::RX_CLR_BASE, 0), 32'h0000_8000);
        wait_act(0, 1'b0);
        u_link.beat(2'd0, 1'b0, 1'b0, 32'h0f0f_0f0f, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK(store_q.size(), 0)
        // writes ignored while clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        wr(rxa(isoch_dma_pkg::RX_SET_BASE, 3), 32'h0000_8000);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(rxa(isoch_dma_pkg::RX_SET_BASE, 3), 32'h4000_0000);
        // reset in mid-run clears pointers and contexts
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd_chk(12'h021c, 32'h0000_0000);
        `CHK(rx_active, 4'h0)
        stop_test();
    end
endmodule : isoch_dma_context_control_test

// >>> isoch_dma_pkg.sv
/*
 * constants, types and register map for the isochronous dma
 * context-control block.
 * assumes a 12-bit byte address on a plain strobe register port.
 */
package isoch_dma_pkg;

    // ***********************************************************
    // sizes
    // ***********************************************************
    localparam int TX_CTX_NUM = 8;
    localparam int RX_CTX_NUM = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CYCLE_W = 13;
    localparam int STAMP_W = 16;
    localparam int STATUS_W = 16;

    // ***********************************************************
    // register map
    // ***********************************************************
    localparam logic [11:0] TX_PTR_BASE = 12'h020C;
    localparam logic [11:0] TX_PTR_STRIDE = 12'h0010;
    localparam logic [11:0] RX_SET_BASE = 12'h0400;
    localparam logic [11:0] RX_CLR_BASE = 12'h0404;
    localparam logic [11:0] RX_MATCH_BASE = 12'h040C;
    localparam logic [11:0] RX_STRIDE = 12'h0020;

    // ***********************************************************
    // field positions and reset values
    // ***********************************************************
    localparam int FILL_BIT = 31;
    localparam int HDR_BIT = 30;
    localparam int CME_BIT = 29;
    localparam int RUN_BIT = 15;
    localparam int ACTIVE_BIT = 10;
    localparam int MATCH_LSB = 12;
    localparam int MATCH_MSB = 24;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [12:0] MATCH_RESET = 13'h0000;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_RUN} rx_state_e;

    typedef struct packed {
        logic valid;
        logic [2:0] ctx;
        logic [31:0] addr;
    } tx_fetch_s;

    typedef struct packed {
        logic valid;
        logic [12:0] count;
        logic [15:0] stamp;
    } cycle_start_s;

    typedef struct packed {
        logic valid;
        logic [1:0] ctx;
        logic is_header;
        logic is_end;
        logic [31:0] data;
        logic [15:0] status;
    } rx_beat_s;

    typedef struct packed {
        logic valid;
        logic [1:0] ctx;
        logic buf_start;
        logic [31:0] data;
    } store_word_s;

endpackage : isoch_dma_pkg

// >>> isoch_link_model.sv
/*
 * behavioural far side of the block: descriptor fetch engine and
 * link layer reporting fetches, cycle starts and received quadlets.
 * assumes one calling process and the block's clock.
 */
`timescale 1ns/1ps
module isoch_link_model (
    // clock
    input wire logic clk,
    // towards the block
    output isoch_dma_pkg::tx_fetch_s tx_fetch,
    output isoch_dma_pkg::cycle_start_s cycle_start,
    output isoch_dma_pkg::rx_beat_s rx_beat
);
    // ********************************
    // idle levels
    // ********************************
    initial begin
        tx_fetch = '0;
        cycle_start = '0;
        rx_beat = '0;
    end

    // ********************************
    // one pulse per event, fields scrambled once released
    // ********************************
    task automatic fetch(input logic [2:0] ctx, input logic [31:0] a);
        @(posedge clk);
        tx_fetch <= {1'b1, ctx, a};
        @(posedge clk);
        tx_fetch <= {1'b0, ~ctx, ~a};
    endtask : fetch

    task automatic cyc(input logic [12:0] cnt, input logic [15:0] st);
        @(posedge clk);
        cycle_start <= {1'b1, cnt, st};
        @(posedge clk);
        cycle_start <= {1'b0, ~cnt, ~st};
    endtask : cyc

    task automatic beat(input logic [1:0] ctx, input logic hdr,
                        input logic last, input logic [31:0] d,
                        input logic [15:0] st);
        @(posedge clk);
        rx_beat <= {1'b1, ctx, hdr, last, d, st};
        @(posedge clk);
        rx_beat <= {1'b0, ~ctx, ~hdr, ~last, ~d, ~st};
    endtask : beat
endmodule : isoch_link_model
